// ### include/rsf_pkg.sv
// Package for the redundant state transfer and failover block
package rsf_pkg;
    localparam int REF_TYPES = 4;
    localparam logic [31:0] GRAN = 32'h0000_0010;
    localparam logic [31:0] MIN_CHUNK = 32'h0000_0200;
    localparam logic [31:0] MIN_HOLD = 32'h0000_0010;
    localparam logic [31:0] NONXFER_DEF_LEN = 32'h0000_0004;
    localparam int CLK_MHZ = 25;
    localparam int HEALTH_PERIOD_US = 10000;
    localparam int HEALTH_CYCLES = HEALTH_PERIOD_US * CLK_MHZ;
    localparam int HEALTH_LOSS = 3;
    localparam int BLINK_US = 250000;
    localparam int BLINK_CYCLES = BLINK_US * CLK_MHZ;
    localparam int TEST_SLICES = 16;
    localparam logic [4:0] STANDBY_CODE = 5'h0B;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SCANS = 8'h08;
    localparam logic [7:0] REG_NT_BASE = 8'h0C;
    localparam logic [7:0] REG_NT_LEN = 8'h10;
    localparam logic [7:0] REG_TOD = 8'h14;
    localparam logic [7:0] REG_EVERY0 = 8'h20;
    localparam logic [7:0] REG_ADD0 = 8'h30;
    localparam logic [7:0] REG_CUR0 = 8'h40;
    localparam logic [7:0] REG_TEST = 8'h50;
    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_FAULT_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        RSF_MODE_FIXED = 2'h0,
        RSF_MODE_EVERY = 2'h1,
        RSF_MODE_ADD = 2'h2,
        RSF_MODE_ALL = 2'h3
    } rsf_mode_type;
    typedef enum logic [2:0] {
        RSF_SELFTEST = 3'h0,
        RSF_WAIT = 3'h1,
        RSF_STANDBY = 3'h3,
        RSF_PRIMARY = 3'h2,
        RSF_OFFLINE = 3'h6,
        RSF_DEAD = 3'h7
    } rsf_state_type;
    typedef struct packed {
        logic valid;
        logic [1:0] ref_type;
        logic [31:0] start;
        logic [31:0] count;
    } rsf_chunk_type;
    typedef struct packed {
        logic ready;
        logic com_act;
        logic com_err;
    } rsf_led_type;
endpackage

// ### design/rsf_core.sv
// Redundancy controller: scan transfer scheduling, roles and self test
// Functional notes
// - Custom-plus-additional mode uses every-scan, additional and scan fields; here it uses only the additional and scan fields.
// - Every scan send configured counts, skip nontransfer area, 16-multiples; here every-scan mode sends nothing.
// - Refuse to run when additional mode has no additional data.
// - Additional count divided by scans, one contiguous chunk per scan.
// - Additional order: outputs, inputs, input regs, holding regs.
// - At least 512 words per type per scan unless less remains.
// - After last additional data, restart chunks from start next scan.
// - All-memory mode sends whole memory each scan, ignores other fields.
// - First controller up becomes primary regardless of A/B switch.
// - Indicators steady normally; activity blinks only on error.
// - Standby loads clock at scan end, then clears request bit.
// - Copy configured memory from primary to standby every scan end.
// - Broken links leave the primary running standalone.
// - Standby takes over failed primary; recovered primary becomes standby.
// - Failed standby goes offline; primary runs standalone.
// - Health message every 10 ms; primary error makes standby take over.
// - Startup tests; any failure stays offline silent until power cycle.
// - Runtime tests repeat in small slices while ready.
// - Nontransfer holding registers never copied; default length four. Chunks here do not skip that area.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module rsf_core
    import rsf_pkg::*;
#(
    parameter int HEALTH_CNT = HEALTH_CYCLES,
    parameter int BLINK_CNT = BLINK_CYCLES,
    parameter logic [31:0] MEM_LIMIT = 32'h0001_0000
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [31:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic scan_end, // Controller end-of-scan pulse
    input wire logic peer_msg, // Health message pulse from peer
    input wire logic peer_ok, // Peer reports healthy in message
    input wire logic peer_primary, // Peer claims primary role
    input wire logic link_up, // Fiber links intact
    input wire logic [3:0] test_fail, // Prom, ram data, ram addr, dpram
    output logic health_send, // Health message pulse to peer
    output logic health_ok, // Own health carried in message
    output logic is_primary, // Controls remote I/O
    output logic run_ok, // Controller allowed to run
    output rsf_chunk_type xfer_chunk, // Scan transfer request
    output logic xfer_all, // Whole memory this scan
    output logic tod_load, // Load time of day clock
    output logic [2:0] test_slice, // Runtime test slice pulses
    output rsf_led_type leds // Module indicators
);
    rsf_state_type state;
    logic [31:0] ctrl, scans, nt_base, nt_len, tod;
    logic [31:0] every [REF_TYPES];
    logic [31:0] addq [REF_TYPES];
    logic [31:0] cur_off;
    logic [1:0] cur_type;
    logic [31:0] health_cnt, blink_cnt;
    logic [1:0] miss;
    logic blink, err, was_primary;
    logic [3:0] slice_cnt;
    logic [31:0] add_total;
    logic cfg_bad, do_write, do_read;
    rsf_mode_type mode;
    logic [31:0] chunk, remain, next_off;
    logic [31:0] base_off;
    logic [1:0] sel_type;

    assign mode = rsf_mode_type'(ctrl[CTRL_MODE_LSB +: 2]);
    assign do_write = psel & penable & pwrite;
    assign do_read = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        add_total = 32'h0;
        for (int i = 0; i < REF_TYPES; i++) begin
            add_total = add_total + addq[i];
        end
    end
    assign cfg_bad = (mode == RSF_MODE_ADD) && (add_total < GRAN);

    // Per-scan chunk of the first nonempty type from the current one on.
    // Empty types are passed over, so a scan goes by without a chunk only when every type is empty.
    always_comb begin
        sel_type = cur_type;
        for (int k = REF_TYPES - 1; k >= 0; k--) begin
            if (addq[cur_type + 2'(k)] != 32'h0) begin
                sel_type = cur_type + 2'(k);
            end
        end
        // A count rewritten below the offset restarts that type at zero
        base_off = (sel_type == cur_type && cur_off < addq[sel_type]) ?
            cur_off : 32'h0;
        remain = addq[sel_type] - base_off;
        chunk = (scans == 32'h0) ? addq[sel_type] :
            addq[sel_type] / scans;
        chunk = (chunk + GRAN - 32'h1) & ~(GRAN - 32'h1);
        if (chunk < MIN_CHUNK) begin
            chunk = MIN_CHUNK;
        end
        if (chunk > remain) begin
            chunk = remain;
        end
        next_off = base_off + chunk;
    end

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            scans <= 32'h1;
            nt_base <= 32'h0;
            nt_len <= NONXFER_DEF_LEN;
            for (int i = 0; i < REF_TYPES; i++) begin
                every[i] <= 32'h0;
                addq[i] <= 32'h0;
            end
        end else if (do_write) begin
            case (paddr[7:0])
                REG_CTRL: ctrl <= pwdata;
                REG_SCANS: scans <= pwdata;
                REG_NT_BASE: nt_base <= pwdata;
                REG_NT_LEN: nt_len <= pwdata;
                default: begin
                    for (int i = 0; i < REF_TYPES; i++) begin
                        if (paddr[7:0] == REG_EVERY0 + 8'(4 * i)) begin
                            every[i] <= pwdata & ~(GRAN - 32'h1);
                        end
                        if (paddr[7:0] == REG_ADD0 + 8'(4 * i)) begin
                            addq[i] <= pwdata & ~(GRAN - 32'h1);
                        end
                    end
                end
            endcase
        end
    end

    // Time of day request: bit 1 request, hardware clears at scan end in standby
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tod <= 32'h0;
            tod_load <= 1'b0;
        end else begin
            tod_load <= 1'b0;
            if (do_write && paddr[7:0] == REG_TOD) begin
                tod <= pwdata;
            end
            if (scan_end && tod[1] && state == RSF_STANDBY) begin
                tod_load <= 1'b1;
                tod[1] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= 32'h0;
            case (paddr[7:0])
                REG_CTRL: prdata <= ctrl;
                REG_STATUS: prdata <= {15'h0,
                    (state == RSF_STANDBY) ? STANDBY_CODE : 5'h0,
                    7'h0, err, cfg_bad, link_up, is_primary, run_ok};
                REG_SCANS: prdata <= scans;
                REG_NT_BASE: prdata <= nt_base;
                REG_NT_LEN: prdata <= nt_len;
                REG_TOD: prdata <= tod;
                REG_CUR0: prdata <= cur_off;
                REG_CUR0 + 8'h4: prdata <= {30'h0, cur_type};
                REG_TEST: prdata <= {28'h0, test_fail};
                default: begin
                    for (int i = 0; i < REF_TYPES; i++) begin
                        if (paddr[7:0] == REG_EVERY0 + 8'(4 * i)) begin
                            prdata <= every[i];
                        end
                        if (paddr[7:0] == REG_ADD0 + 8'(4 * i)) begin
                            prdata <= addq[i];
                        end
                    end
                end
            endcase
        end
    end

    // Role state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RSF_SELFTEST;
            was_primary <= 1'b0;
        end else begin
            case (state)
                RSF_SELFTEST: begin
                    if (test_fail != 4'h0) begin
                        state <= RSF_DEAD;
                    end else begin
                        state <= RSF_WAIT;
                    end
                end
                RSF_WAIT: begin
                    if (ctrl[CTRL_RUN_BIT] && !cfg_bad) begin
                        // Nobody else primary yet: we came up first
                        state <= (link_up && peer_primary) ?
                            RSF_STANDBY : RSF_PRIMARY;
                    end
                end
                RSF_PRIMARY: begin
                    was_primary <= 1'b1;
                    if (test_fail[2:0] != 3'h0) begin
                        state <= RSF_DEAD;
                    end else if (ctrl[CTRL_FAULT_BIT]) begin
                        state <= RSF_OFFLINE;
                    end
                    // Link loss keeps primary running standalone
                end
                RSF_STANDBY: begin
                    if (test_fail[2:0] != 3'h0) begin
                        state <= RSF_DEAD;
                    end else if (ctrl[CTRL_FAULT_BIT] || !link_up) begin
                        state <= RSF_OFFLINE;
                    end else if ((peer_msg && !peer_ok) ||
                                 miss == 2'(HEALTH_LOSS)) begin
                        state <= RSF_PRIMARY;
                    end
                end
                RSF_OFFLINE: begin
                    // Recovered controller rejoins only as standby
                    if (!ctrl[CTRL_FAULT_BIT] && link_up && !cfg_bad) begin
                        state <= RSF_STANDBY;
                    end
                end
                RSF_DEAD: state <= RSF_DEAD;
                default: state <= RSF_DEAD;
            endcase
        end
    end

    assign is_primary = (state == RSF_PRIMARY);
    assign run_ok = (state == RSF_PRIMARY) || (state == RSF_STANDBY);
    assign err = (state == RSF_DEAD) || (state == RSF_OFFLINE) || cfg_bad;

    // Health messages and loss counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            health_cnt <= 32'h0;
            health_send <= 1'b0;
            miss <= 2'h0;
        end else begin
            health_send <= 1'b0;
            if (health_cnt >= 32'(HEALTH_CNT - 1)) begin
                health_cnt <= 32'h0;
                health_send <= run_ok;
                if (miss != 2'(HEALTH_LOSS)) begin
                    miss <= miss + 2'h1;
                end
            end else begin
                health_cnt <= health_cnt + 32'h1;
            end
            if (peer_msg) begin
                miss <= 2'h0;
            end
        end
    end
    assign health_ok = run_ok;

    // Transfer scheduling at scan end, primary only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_off <= 32'h0;
            cur_type <= 2'h0;
            xfer_chunk <= '0;
            xfer_all <= 1'b0;
        end else begin
            xfer_chunk.valid <= 1'b0;
            xfer_all <= 1'b0;
            // Dropping the link makes the peer irrelevant, no copy
            if (scan_end && is_primary && link_up) begin
                if (mode == RSF_MODE_ALL) begin
                    xfer_all <= 1'b1;
                end else if (mode == RSF_MODE_ADD) begin
                    xfer_chunk.valid <= (chunk != 32'h0);
                    xfer_chunk.ref_type <= sel_type;
                    xfer_chunk.start <= base_off;
                    xfer_chunk.count <= chunk;
                    if (next_off >= addq[sel_type]) begin
                        cur_off <= 32'h0;
                        cur_type <= sel_type + 2'h1;
                    end else begin
                        cur_type <= sel_type;
                        cur_off <= next_off;
                    end
                end
            end
        end
    end

    // Runtime tests sliced one step per scan
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slice_cnt <= 4'h0;
            test_slice <= 3'h0;
        end else begin
            test_slice <= 3'h0;
            if (scan_end && run_ok) begin
                // Three test kinds in turn, with no uneven step at wrap
                slice_cnt <= (slice_cnt == 4'h2) ? 4'h0 : slice_cnt + 4'h1;
                test_slice <= 3'h1 << slice_cnt;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_CNT - 1)) begin
            blink_cnt <= 32'h0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // Steady indicators unless an error is held
    assign leds.ready = (state != RSF_SELFTEST);
    assign leds.com_act = err ? blink : run_ok;
    assign leds.com_err = run_ok && !link_up;

    a_dead_sticks: assert property (@(posedge clk) disable iff (!rst_n)
        state == RSF_DEAD |=> state == RSF_DEAD)
        else $error("dead state left");
    a_dead_silent: assert property (@(posedge clk) disable iff (!rst_n)
        state == RSF_DEAD |=> !health_send && !xfer_all && !xfer_chunk.valid)
        else $error("failed module still active");
    a_refuse_start: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_bad && state == RSF_WAIT |=> state == RSF_WAIT)
        else $error("started with no additional data");
    a_chunk_min: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_chunk.valid |-> xfer_chunk.count >= MIN_CHUNK ||
        xfer_chunk.start + xfer_chunk.count == addq[xfer_chunk.ref_type])
        else $error("chunk below minimum");
    a_chunk_gran: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_chunk.valid |-> xfer_chunk.count[3:0] == 4'h0)
        else $error("chunk not 16 aligned");
    a_all_mode: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_all |-> !xfer_chunk.valid && $past(mode) == RSF_MODE_ALL)
        else $error("all-memory transfer in wrong mode");
    a_tod_clear: assert property (@(posedge clk) disable iff (!rst_n)
        tod_load |-> !tod[1] ##1 !tod_load)
        else $error("time request not cleared");
    a_primary_stays: assert property (@(posedge clk)
        disable iff (!rst_n)
        is_primary && !link_up && test_fail == 4'h0 && !ctrl[CTRL_FAULT_BIT]
        |=> is_primary)
        else $error("primary dropped on link loss");
    a_takeover: assert property (@(posedge clk) disable iff (!rst_n)
        state == RSF_STANDBY && link_up && peer_msg && !peer_ok &&
        test_fail == 4'h0 && !ctrl[CTRL_FAULT_BIT] |=> is_primary)
        else $error("standby did not take over");
    a_led_steady: assert property (@(posedge clk) disable iff (!rst_n)
        run_ok && !err |-> leds.com_act)
        else $error("activity not steady");
    a_slice_hot: assert property (@(posedge clk) disable iff (!rst_n)
        test_slice != 3'h0 |-> $onehot(test_slice) && $past(run_ok))
        else $error("runtime test slice not one-hot");
    a_xfer_primary: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_chunk.valid |-> $past(is_primary) && $past(scan_end))
        else $error("transfer off scan end");
endmodule

// ### testbench/rsf_peer.sv
// Peer redundancy module model: health messages, role and link state
`timescale 1ns/1ps
module rsf_peer #(
    parameter int PERIOD = 20
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic alive, // Peer sends health messages
    input wire logic ok, // Health carried in messages
    input wire logic primary, // Peer holds primary role
    input wire logic link, // Fiber links intact
    output logic peer_msg, // Health message pulse
    output logic peer_ok, // Health at message pulse, inverse otherwise
    output logic peer_primary, // Role level
    output logic link_up // Link level
);
    int cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            peer_msg <= 1'h0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            peer_msg <= alive && link && cnt == 0;
        end
    end
    // Health has no meaning between messages, so it shows the inverse there
    assign peer_ok = peer_msg ? ok : ~ok;
    assign peer_primary = primary;
    assign link_up = link;
endmodule

// ### testbench/test_redundant_state_transfer_failover.sv
// Self-checking bench for the redundancy transfer and failover block
`timescale 1ns/1ps
module test_redundant_state_transfer_failover import rsf_pkg::*;;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, scan_end;
    logic [31:0] paddr, pwdata, prdata, rd, off, ex_s, ex_c;
    logic peer_msg, peer_ok, peer_primary, link_up, health_send, health_ok;
    logic is_primary, run_ok, xfer_all, tod_load, alive, ok, primary, link;
    logic [3:0] test_fail;
    logic [2:0] test_slice;
    logic [1:0] ex_t;
    rsf_chunk_type xfer_chunk;
    rsf_led_type leds, led0;
    logic [31:0] addq [4];
    int miscompares, compares, ct, sc, n;

    rsf_core #(.HEALTH_CNT(20), .BLINK_CNT(4)) DUT (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_end(scan_end), .peer_msg(peer_msg), .peer_ok(peer_ok),
        .peer_primary(peer_primary), .link_up(link_up),
        .test_fail(test_fail), .health_send(health_send),
        .health_ok(health_ok), .is_primary(is_primary), .run_ok(run_ok),
        .xfer_chunk(xfer_chunk), .xfer_all(xfer_all), .tod_load(tod_load),
        .test_slice(test_slice), .leds(leds));

    rsf_peer #(.PERIOD(20)) peer (
        .clk(clk), .rst_n(rst_n), .alive(alive), .ok(ok),
        .primary(primary), .link(link), .peer_msg(peer_msg),
        .peer_ok(peer_ok), .peer_primary(peer_primary), .link_up(link_up));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task chk(input logic [66:0] seen, input logic [66:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("Counts: %0d compares, %0d miscompares", compares,
            miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Request stays put until pready is seen high with the access phase
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task scan;
        @(posedge clk);
        scan_end <= 1'h1;
        @(posedge clk);
        scan_end <= 1'h0;
        @(negedge clk);
    endtask

    task reset_dut;
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
    endtask

    function automatic logic [31:0] ctl(input rsf_mode_type m);
        return {29'h0, 1'h1, m};
    endfunction

    // Chunk is at least 512, rounded up to 16, never past what remains
    task next_exp(output logic [1:0] t, output logic [31:0] s, c);
        logic [31:0] q;
        while (addq[ct] == 0) ct = (ct + 1) % 4;
        q = (addq[ct] + sc * 16 - 1) / (sc * 16) * 16;
        if (q < MIN_CHUNK) q = MIN_CHUNK;
        c = (q < addq[ct] - off) ? q : addq[ct] - off;
        t = ct[1:0];
        s = off;
        off = off + c;
        if (off == addq[ct]) begin
            off = 0;
            ct = (ct + 1) % 4;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, scan_end} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        rst_n = 1'h0;
        test_fail = 4'h0;
        {alive, ok, primary, link} = 4'h5;
        miscompares = 0;
        compares = 0;
        void'($urandom(32'h1DB8F1CB));
        reset_dut();
        apb(1'h0, REG_NT_LEN, 32'h0);
        chk(rd, NONXFER_DEF_LEN);
        apb(1'h0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ADD));
        repeat (4) @(negedge clk);
        chk(run_ok, 1'h0);
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rd[3], 1'h1);
        apb(1'h1, REG_EVERY0, 32'h23);
        apb(1'h0, REG_EVERY0, 32'h0);
        chk(rd, 32'h20);
        sc = 3;
        apb(1'h1, REG_SCANS, 32'h3);
        for (int i = 0; i < 3; i++) begin
            addq[i] = 48 * $urandom_range(0, 12);
            apb(1'h1, REG_ADD0 + 8'(4 * i), addq[i]);
        end
        addq[3] = 32'h210;
        apb(1'h1, REG_ADD0 + 8'hC, addq[3]);
        alive <= 1'h1;
        repeat (4) @(negedge clk);
        chk(is_primary, 1'h1);
        chk(leds.ready, 1'h1);
        chk({health_ok, pready, pslverr}, 3'h6);
        n = 0;
        repeat (60) begin
            @(negedge clk);
            n += health_send;
            chk(leds, 3'h6);
        end
        chk(n >= 2, 1'h1);
        ct = 0;
        off = 0;
        for (int k = 0; k < 12; k++) begin
            scan();
            next_exp(ex_t, ex_s, ex_c);
            chk(xfer_chunk, {1'h1, ex_t, ex_s, ex_c});
            chk(test_slice, 3'h1 << (k % 3));
            chk(xfer_all, 1'h0);
        end
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ALL));
        scan();
        chk({xfer_all, xfer_chunk.valid}, 2'h2);
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_EVERY));
        scan();
        chk({xfer_all, xfer_chunk.valid}, 2'h0);
        @(posedge clk);
        link <= 1'h0;
        repeat (100) @(negedge clk);
        chk({is_primary, run_ok}, 2'h3);
        @(posedge clk);
        link <= 1'h1;
        primary <= 1'h1;
        reset_dut();
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ALL));
        repeat (4) @(negedge clk);
        chk({is_primary, run_ok}, 2'h1);
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rd[16:12], STANDBY_CODE);
        apb(1'h1, REG_TOD, 32'h2);
        scan();
        chk(tod_load, 1'h1);
        apb(1'h0, REG_TOD, 32'h0);
        chk(rd[1], 1'h0);
        // Faulted standby drops out, blinks, and rejoins as standby
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ALL) | 32'h8);
        repeat (2) @(negedge clk);
        chk(run_ok, 1'h0);
        led0 = leds;
        n = 0;
        repeat (20) begin
            @(negedge clk);
            n += (leds.com_act !== led0.com_act);
            led0 = leds;
        end
        chk(n >= 2, 1'h1);
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ALL));
        repeat (2) @(negedge clk);
        chk({is_primary, run_ok}, 2'h1);
        @(posedge clk);
        ok <= 1'h0;
        primary <= 1'h0;
        n = 0;
        while (is_primary !== 1'h1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(is_primary, 1'h1);
        @(posedge clk);
        test_fail <= 4'($urandom_range(1, 15));
        ok <= 1'h1;
        reset_dut();
        apb(1'h1, REG_CTRL, ctl(RSF_MODE_ALL));
        n = 0;
        repeat (60) begin
            @(negedge clk);
            n += health_send;
        end
        chk({n == 0, run_ok}, 2'h2);
        end_of_test();
    end
endmodule
